// *** core/rtcrw_pkg.sv ***
`default_nettype none
package rtcrw_pkg;

  // Register word indices on the plain port (byte address = 4 * index)
  localparam logic [3:0] ADDR_CONFIG      = 4'h0;
  localparam logic [3:0] ADDR_VALUE_WIN   = 4'h1;
  localparam logic [3:0] ADDR_ALARM_CFG   = 4'h2;
  localparam logic [3:0] ADDR_ALARM_WIN   = 4'h3;
  localparam logic [3:0] ADDR_UNLOCK_KEY  = 4'h4;
  localparam logic [3:0] ADDR_TIME_STATUS = 4'h5;

  // Configuration register fields
  localparam int BIT_MODULE_ENABLE = 15;
  localparam int BIT_UNUSED_14     = 14;
  localparam int BIT_WRITE_ENABLE  = 13;
  localparam int BIT_SYNC_STATUS   = 12;
  localparam int BIT_HALF_SECOND   = 11;
  localparam int BIT_OUTPUT_ENABLE = 10;
  localparam int PTR_HI            = 9;
  localparam int PTR_LO            = 8;
  localparam int CAL_HI            = 7;
  localparam int CAL_LO            = 0;

  localparam logic [15:0] CONFIG_RESET    = 16'h0000;
  localparam logic [15:0] ALARM_CFG_RESET = 16'h0000;
  localparam logic [7:0]  VALUE_RESET     = 8'h00;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Write-enable setting must follow the key within this many cycles
  localparam int          UNLOCK_WINDOW_CYCLES = 1;
  localparam logic [1:0]  PTR_MIN_SEC          = 2'b00;
  localparam logic [1:0]  PTR_WDAY_HOUR        = 2'b01;
  localparam logic [1:0]  PTR_MONTH_DAY        = 2'b10;
  localparam logic [1:0]  PTR_YEAR             = 2'b11;

  // Calibration: 4 clock pulses per minute per step
  localparam int CAL_PULSES_PER_STEP = 4;

  typedef enum logic [2:0]
  {
    RTCRW_KEY_IDLE  = 3'b001,
    RTCRW_KEY_HALF  = 3'b010,
    RTCRW_KEY_OPEN  = 3'b100
  } rtcrw_key_e;

endpackage : rtcrw_pkg
`default_nettype wire

// *** core/rtcrw_unlock.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtcrw_unlock
(
  input  wire logic       clk_i,      // System clock
  input  wire logic       rst_n_i,    // Power-on reset, active low
  input  wire logic       key_wr_i,   // Write to key register
  input  wire logic [7:0] key_data_i, // Key byte
  input  wire logic       any_wr_i,   // Any register write this cycle
  output logic            open_o      // Unlock window open
);

  rtcrw_pkg::rtcrw_key_e state;
  rtcrw_pkg::rtcrw_key_e next_state;

  always_comb
  begin
    next_state = state;
    case (state)
      rtcrw_pkg::RTCRW_KEY_IDLE:
        if (key_wr_i && key_data_i == rtcrw_pkg::KEY_FIRST)
          next_state = rtcrw_pkg::RTCRW_KEY_HALF;
      rtcrw_pkg::RTCRW_KEY_HALF:
        if (key_wr_i && key_data_i == rtcrw_pkg::KEY_SECOND)
          next_state = rtcrw_pkg::RTCRW_KEY_OPEN;
        else if (any_wr_i)
          next_state = rtcrw_pkg::RTCRW_KEY_IDLE;
      rtcrw_pkg::RTCRW_KEY_OPEN:
        // Window lasts one cycle, used or not
        if (key_wr_i && key_data_i == rtcrw_pkg::KEY_FIRST)
          next_state = rtcrw_pkg::RTCRW_KEY_HALF;
        else
          next_state = rtcrw_pkg::RTCRW_KEY_IDLE;
      default:
        next_state = rtcrw_pkg::RTCRW_KEY_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      state <= rtcrw_pkg::RTCRW_KEY_IDLE;
    else
      state <= next_state;
  end

  assign open_o = (state == rtcrw_pkg::RTCRW_KEY_OPEN);

endmodule : rtcrw_unlock
`default_nettype wire

// *** core/rtcrw_window.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtcrw_window
#(
  parameter bit ALLOW_RESERVED = 1'b1 // Pointer 11 selects low byte pair
)
(
  input  wire logic        clk_i,     // System clock
  input  wire logic        rst_n_i,   // Power-on reset, active low
  input  wire logic        ptr_wr_i,  // Software loads pointer
  input  wire logic [1:0]  ptr_din_i, // New pointer value
  input  wire logic        step_i,    // Access that steps pointer down
  input  wire logic        wr_i,      // Write of window data
  input  wire logic [15:0] din_i,     // Window write data
  output logic      [1:0]  ptr_o,     // Current pointer
  output logic      [15:0] dout_o,    // Window read data
  output logic      [63:0] regs_o     // All pairs, pair n at [16n+:16]
);

  logic [15:0] pair [4];

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      ptr_o <= rtcrw_pkg::PTR_MIN_SEC;
    else if (ptr_wr_i)
      ptr_o <= ptr_din_i;
    else if (step_i && ptr_o != rtcrw_pkg::PTR_MIN_SEC)
      ptr_o <= ptr_o - 2'd1;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pair
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
          pair[g] <= {rtcrw_pkg::VALUE_RESET, rtcrw_pkg::VALUE_RESET};
        else if (wr_i && ptr_o == 2'(g))
        begin
          // Reserved bytes hold nothing
          if (g == 3)
            pair[g] <= ALLOW_RESERVED ? {8'h00, din_i[7:0]} : 16'h0000;
          else
            pair[g] <= din_i;
        end
      end
      assign regs_o[16*g +: 16] = pair[g];
    end
  endgenerate

  assign dout_o = pair[ptr_o];

endmodule : rtcrw_window
`default_nettype wire

// *** core/rtcrw_top.sv ***
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rtcrw_top
(
  input  wire logic        clk_i,          // 20 MHz system clock
  input  wire logic        rst_n_i,        // Power-on reset, active low
  input  wire logic [3:0]  addr_i,         // Register word index
  input  wire logic [15:0] wdata_i,        // Write data
  input  wire logic        wr_i,           // Write strobe
  input  wire logic        rd_i,           // Read strobe
  output logic      [15:0] rdata_o,        // Read data, cycle after rd_i
  input  wire logic        half_second_i,  // Second-half phase from counters
  input  wire logic        ripple_i,       // Rollover ripple pending
  output logic             module_enable_o,  // Clock module runs
  output logic             output_enable_o,  // Clock output pin enabled
  output logic signed [9:0] cal_pulses_o,  // Pulses per minute adjustment
  output logic      [63:0] time_regs_o,    // Timekeeping pairs
  output logic      [63:0] alarm_regs_o    // Alarm pairs
);

  logic [15:0] config_reg;
  logic [15:0] alarm_cfg;
  logic        half_clear;
  logic        open;
  logic        wr_cfg;
  logic        wr_val;
  logic        wr_alm;
  logic        wr_acfg;
  logic        rd_val;
  logic        rd_alm;
  logic [1:0]  val_ptr;
  logic [1:0]  alm_ptr;
  logic [15:0] val_dout;
  logic [15:0] alm_dout;
  logic        val_write_ok;
  logic        half_status;

  assign wr_cfg  = wr_i && addr_i == rtcrw_pkg::ADDR_CONFIG;
  assign wr_val  = wr_i && addr_i == rtcrw_pkg::ADDR_VALUE_WIN;
  assign wr_alm  = wr_i && addr_i == rtcrw_pkg::ADDR_ALARM_WIN;
  assign wr_acfg = wr_i && addr_i == rtcrw_pkg::ADDR_ALARM_CFG;
  assign rd_val  = rd_i && addr_i == rtcrw_pkg::ADDR_VALUE_WIN;
  assign rd_alm  = rd_i && addr_i == rtcrw_pkg::ADDR_ALARM_WIN;

  // Full-word port: every window write carries the high byte
  assign val_write_ok = wr_val && config_reg[rtcrw_pkg::BIT_WRITE_ENABLE];

  rtcrw_unlock u_unlock
  (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .key_wr_i   (wr_i && addr_i == rtcrw_pkg::ADDR_UNLOCK_KEY),
    .key_data_i (wdata_i[7:0]),
    .any_wr_i   (wr_i),
    .open_o     (open)
  );

  // Only power-on reset reaches this register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      config_reg <= rtcrw_pkg::CONFIG_RESET;
    else if (wr_cfg)
    begin
      // Clearing write enable is always allowed; setting needs the key
      if (!wdata_i[rtcrw_pkg::BIT_WRITE_ENABLE])
        config_reg[rtcrw_pkg::BIT_WRITE_ENABLE] <= 1'b0;
      else if (open)
        config_reg[rtcrw_pkg::BIT_WRITE_ENABLE] <= 1'b1;
      if (config_reg[rtcrw_pkg::BIT_WRITE_ENABLE])
        config_reg[rtcrw_pkg::BIT_MODULE_ENABLE] <=
          wdata_i[rtcrw_pkg::BIT_MODULE_ENABLE];
      config_reg[rtcrw_pkg::BIT_OUTPUT_ENABLE] <=
        wdata_i[rtcrw_pkg::BIT_OUTPUT_ENABLE];
      config_reg[rtcrw_pkg::CAL_HI:rtcrw_pkg::CAL_LO] <=
        wdata_i[rtcrw_pkg::CAL_HI:rtcrw_pkg::CAL_LO];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      alarm_cfg <= rtcrw_pkg::ALARM_CFG_RESET;
    else if (wr_acfg)
      alarm_cfg <= wdata_i;
  end

  // Clear holds until the counters enter the next half-second
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      half_clear <= 1'b0;
    else if (val_write_ok && val_ptr == rtcrw_pkg::PTR_MIN_SEC)
      half_clear <= 1'b1;
    else if (!half_second_i)
      half_clear <= 1'b0;
  end

  assign half_status = half_second_i && !half_clear;

  rtcrw_window #(.ALLOW_RESERVED(1'b1)) u_value
  (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .ptr_wr_i  (wr_cfg),
    .ptr_din_i (wdata_i[rtcrw_pkg::PTR_HI:rtcrw_pkg::PTR_LO]),
    .step_i    (val_write_ok || rd_val),
    .wr_i      (val_write_ok),
    .din_i     (wdata_i),
    .ptr_o     (val_ptr),
    .dout_o    (val_dout),
    .regs_o    (time_regs_o)
  );

  rtcrw_window #(.ALLOW_RESERVED(1'b0)) u_alarm
  (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .ptr_wr_i  (wr_acfg),
    .ptr_din_i (wdata_i[rtcrw_pkg::PTR_HI:rtcrw_pkg::PTR_LO]),
    .step_i    (wr_alm || rd_alm),
    .wr_i      (wr_alm),
    .din_i     (wdata_i),
    .ptr_o     (alm_ptr),
    .dout_o    (alm_dout),
    .regs_o    (alarm_regs_o)
  );

  // Read data sampled before the pointer step takes effect
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      case (addr_i)
        rtcrw_pkg::ADDR_CONFIG:
          rdata_o <= {config_reg[rtcrw_pkg::BIT_MODULE_ENABLE],
                      1'b0,
                      config_reg[rtcrw_pkg::BIT_WRITE_ENABLE],
                      ripple_i,
                      half_status,
                      config_reg[rtcrw_pkg::BIT_OUTPUT_ENABLE],
                      val_ptr,
                      config_reg[rtcrw_pkg::CAL_HI:rtcrw_pkg::CAL_LO]};
        rtcrw_pkg::ADDR_VALUE_WIN:
          rdata_o <= val_dout;
        rtcrw_pkg::ADDR_ALARM_CFG:
          rdata_o <= {alarm_cfg[15:10], alm_ptr, alarm_cfg[7:0]};
        rtcrw_pkg::ADDR_ALARM_WIN:
          rdata_o <= alm_dout;
        rtcrw_pkg::ADDR_TIME_STATUS:
          rdata_o <= {14'h0000, ripple_i, half_status};
        default:
          rdata_o <= 16'h0000;
      endcase
    end
    else
      rdata_o <= 16'h0000;
  end

  assign module_enable_o = config_reg[rtcrw_pkg::BIT_MODULE_ENABLE];
  assign output_enable_o = config_reg[rtcrw_pkg::BIT_OUTPUT_ENABLE];
  // Signed step count times pulses per step
  assign cal_pulses_o = 10'(signed'(config_reg[7:0]))
                        * 10'(rtcrw_pkg::CAL_PULSES_PER_STEP);

endmodule : rtcrw_top
`default_nettype wire

// *** test/rtcrw_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtcrw_props
(
  input  wire logic               clk_i,           // Clock
  input  wire logic               rst_n_i,         // Reset, active low
  input  wire logic        [3:0]  addr_i,          // Word index
  input  wire logic        [15:0] wdata_i,         // Write data
  input  wire logic               wr_i,            // Write strobe
  input  wire logic               rd_i,            // Read strobe
  input  wire logic        [15:0] rdata_o,         // Read data
  input  wire logic               half_second_i,   // Second-half phase
  input  wire logic               ripple_i,        // Ripple pending
  input  wire logic               module_enable_o, // Module runs
  input  wire logic               output_enable_o, // Pin enabled
  input  wire logic signed [9:0]  cal_pulses_o,    // Adjustment
  input  wire logic        [63:0] time_regs_o,     // Time pairs
  input  wire logic        [63:0] alarm_regs_o     // Alarm pairs
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic cfg_wr = wr_i && addr_i == 4'h0;
  wire logic cfg_rd = rd_i && addr_i == 4'h0;

  a_cal_scale: assert property (cfg_wr |=> cal_pulses_o ==
    {$past(wdata_i[7:0]), 2'b00})
    else $error("calibration scaling wrong");
  a_oe_follow: assert property (cfg_wr |=>
    output_enable_o == $past(wdata_i[10])) else $error("output enable wrong");
  a_cfg_fixed: assert property (cfg_rd |=> !rdata_o[14] &&
    rdata_o[12] == $past(ripple_i)) else $error("config status bits wrong");
  a_half_low: assert property (cfg_rd && !half_second_i |=>
    !rdata_o[11]) else $error("half second set in first half");
  a_en_source: assert property ($rose(module_enable_o) |->
    $past(cfg_wr)) else $error("enable rose without config write");
  a_time_lock: assert property ($changed(time_regs_o) |->
    $past(wr_i && addr_i == 4'h1)) else $error("time changed unasked");
  a_alarm_none: assert property (alarm_regs_o[63:48] == 16'h0000)
    else $error("alarm pair three not empty");
  a_alarm_src: assert property ($changed(alarm_regs_o) |->
    $past(wr_i && addr_i == 4'h3)) else $error("alarm changed unasked");

  c_enable: cover property ($rose(module_enable_o));
  c_val_rd: cover property (rd_i && addr_i == 4'h1);
  c_alm_wr: cover property (wr_i && addr_i == 4'h3);
endmodule : rtcrw_props

bind rtcrw_top rtcrw_props u_props
(
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ripple_i(ripple_i),
  .half_second_i(half_second_i), .module_enable_o(module_enable_o),
  .output_enable_o(output_enable_o), .cal_pulses_o(cal_pulses_o),
  .time_regs_o(time_regs_o), .alarm_regs_o(alarm_regs_o)
);
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  error_cnt++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module tb_top;
  logic               clk_i;
  logic               rst_n_i;
  logic        [3:0]  addr_i;
  logic        [15:0] wdata_i;
  logic               wr_i;
  logic               rd_i;
  logic               half_second_i;
  logic               ripple_i;
  logic        [15:0] rdata_o;
  logic               module_enable_o;
  logic               output_enable_o;
  logic signed [9:0]  cal_pulses_o;
  logic        [63:0] time_regs_o;
  logic        [63:0] alarm_regs_o;
  int                 error_cnt = 0;
  int                 check_count = 0;

  rtcrw_top u_dut
  (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ripple_i(ripple_i),
    .half_second_i(half_second_i), .module_enable_o(module_enable_o),
    .output_enable_o(output_enable_o), .cal_pulses_o(cal_pulses_o),
    .time_regs_o(time_regs_o), .alarm_regs_o(alarm_regs_o)
  );

  task stop_test;
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // Strobe stays up so writes can run back to back
  task wr(input logic [3:0] a, input logic [15:0] d);
    rd_i    <= 1'b0;
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
  endtask : wr

  task idle;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask : idle

  task rd(input logic [3:0] a, input logic [15:0] e);
    wr_i   <= 1'b0;
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, e)
    @(posedge clk_i);
  endtask : rd

  task rd5(input logic [3:0] a, input logic [15:0] e [5]);
    for (int i = 0; i < 5; i++)
      rd(a, e[i]);
  endtask : rd5

  task t_lock;
    rd(4'h0, 16'h0000);
    wr(4'h1, 16'h1234);
    wr(4'h0, 16'h8000);
    wr(4'h4, 16'h0055);
    wr(4'h4, 16'h00AA);
    idle;
    wr(4'h0, 16'h2000);
    idle;
    `CHK(time_regs_o[15:0], 16'h0000)
    `CHK(module_enable_o, 1'b0)
    rd(4'h0, 16'h0000);
    rd(4'hF, 16'h0000);
  endtask : t_lock

  task t_unlock;
    wr(4'h4, 16'h0055);
    wr(4'h4, 16'h00AA);
    wr(4'h0, 16'h2000);
    wr(4'h0, 16'hE783);
    idle;
    half_second_i <= 1'b1;
    ripple_i      <= 1'b1;
    rd(4'h0, 16'hBF83);
    rd(4'h5, 16'h0003);
    `CHK(module_enable_o, 1'b1)
    `CHK(output_enable_o, 1'b1)
    `CHK(cal_pulses_o, 10'h20C)
  endtask : t_unlock

  // Pointer starts at 11 and must saturate at 00
  task t_time_win;
    wr(4'h1, 16'hFF19);
    wr(4'h1, 16'h0612);
    wr(4'h1, 16'h0309);
    wr(4'h1, 16'h4530);
    wr(4'h1, 16'h4531);
    idle;
    `CHK(time_regs_o[47:0], 48'h0612_0309_4531)
    rd(4'h0, 16'hB483);
    ripple_i      <= 1'b0;
    half_second_i <= 1'b0;
    wr(4'h0, 16'h2300);
    idle;
    rd5(4'h1, '{16'h0019, 16'h0612, 16'h0309, 16'h4531, 16'h4531});
    // Ripple pending: read twice, pointer already parked at 00
    ripple_i <= 1'b1;
    rd(4'h1, 16'h4531);
    rd(4'h1, 16'h4531);
    ripple_i <= 1'b0;
    // Relock without the key, then a stray write must not land
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h9999);
    idle;
    `CHK(time_regs_o[15:0], 16'h4531)
  endtask : t_time_win

  task t_alarm_win;
    wr(4'h2, 16'h0300);
    wr(4'h3, 16'h1111);
    wr(4'h3, 16'h2233);
    wr(4'h3, 16'h4455);
    wr(4'h3, 16'h6677);
    idle;
    `CHK(alarm_regs_o, 64'h0000_2233_4455_6677)
    wr(4'h2, 16'h0300);
    idle;
    rd(4'h2, 16'h0300);
    rd5(4'h3, '{16'h0000, 16'h2233, 16'h4455, 16'h6677, 16'h6677});
  endtask : t_alarm_win

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Run needs about 80 cycles; 400 leaves a wide margin
  initial
  begin
    #20000;
    error_cnt++;
    stop_test;
  end

  initial
  begin
    rst_n_i       = 1'b0;
    addr_i        = 4'h0;
    wdata_i       = 16'h0000;
    wr_i          = 1'b0;
    rd_i          = 1'b0;
    half_second_i = 1'b0;
    ripple_i      = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_lock;
    t_unlock;
    t_time_win;
    t_alarm_win;
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
